// *** design/idio_params.svh ***
// timing, offsets, field positions and reset values of the discrete io block
`ifndef IDIO_PARAMS_SVH
`define IDIO_PARAMS_SVH
`define IDIO_CLK_HZ 50000000
`define IDIO_TICK_MS 1
`define IDIO_TICK_CYC ((`IDIO_CLK_HZ / 1000) * `IDIO_TICK_MS)
`define IDIO_PULSE_MS 50
// register byte offsets
`define IDIO_OFS_CTRL 12'h000
`define IDIO_OFS_OUTCFG 12'h004
`define IDIO_OFS_SER 12'h008
`define IDIO_OFS_DELIM 12'h00C
`define IDIO_OFS_STAT 12'h010
`define IDIO_OFS_CMD 12'h014
`define IDIO_OFS_SCAN 12'h018
// ctrl fields
`define IDIO_CTRL_POL 0
`define IDIO_CTRL_CMP 1
`define IDIO_CTRL_HOLD 2
`define IDIO_CTRL_DEXP 3
`define IDIO_CTRL_IEXP 4
`define IDIO_CTRL_ETH 5
`define IDIO_CTRL_CONT 6
// cmd fields
`define IDIO_CMD_HIST 0
`define IDIO_CMD_FCLR 1
// output config: per output 3 bits select, 1 bit pulsed, 8 bits width ms
`define IDIO_OC_SEL_W 3
`define IDIO_OC_FLD_W 12
`define IDIO_OC_PUL 3
`define IDIO_OC_WID_LSB 4
`define IDIO_RST_OUTCFG 36'h320_321_320
`define IDIO_RST_SER 32'h0000_1C20
`define IDIO_RST_DELIM 32'h0022_0D2C
`define IDIO_RST_SCAN 32'h0000_0001
`define IDIO_PSLVERR_OK 1'b0
`endif

// *** design/idio_pkg.sv ***
// types shared by the discrete io block
package idio_pkg;
    typedef enum logic [2:0] {
        IDIO_C_PASS, IDIO_C_FAIL, IDIO_C_READ, IDIO_C_NOREAD,
        IDIO_C_MATCH, IDIO_C_NOMATCH, IDIO_C_MISSED, IDIO_C_FAULT
    } idio_cond_e;
    typedef enum logic [1:0] {IDIO_S_IDLE, IDIO_S_BUSY, IDIO_S_QUEUE} idio_state_e;
    typedef struct packed {
        logic [2:0] trg_sync;
        logic [2:0] tch_sync;
        logic trg_prev;
        logic tch_prev;
        idio_state_e st;
        logic [31:0] ctrl;
        logic [35:0] outcfg;
        logic [31:0] ser;
        logic [31:0] delim;
        logic [31:0] scan;
        logic [31:0] prdata;
        logic pol_seen;
        logic missed;
        logic fault;
        logic rd_flag;
        logic nord_flag;
        logic match_flag;
        logic nomatch_flag;
        logic cmp_ok;
        logic [2:0] lvl;
        logic [2:0] out;
        logic [23:0] pul_ms;
        logic [15:0] tick_cnt;
        logic res_seen;
        logic cap;
        logic dexp;
        logic iexp;
        logic drop;
    } idio_state_s;
endpackage

// *** design/idio_top.sv ***
// discrete trigger/teach inputs, result outputs and export flow control
`include "idio_params.svh"
`timescale 1ns/100ps
`default_nettype none
module idio_top
    import idio_pkg::*;
#(
    parameter int TICK_CYC = `IDIO_TICK_CYC
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    // strap: high on sinking variant
    input wire logic SINK_VARIANT_I,
    // discrete pins
    input wire logic TRIGGER_I,
    input wire logic TEACH_I,
    output logic [2:0] RESULT_O,
    output logic READY_O,
    output logic TEACH_O,
    // inspection core
    output logic CAPTURE_O,
    input wire logic INSP_DONE_I,
    input wire logic [7:0] CODES_FOUND_I,
    input wire logic CMP_OK_I,
    input wire logic FATAL_I,
    // export channels
    input wire logic CHAN_FULL_I,
    output logic DATA_EXP_O,
    output logic IMG_EXP_O,
    output logic DROP_O,
    // serial and delimiter settings
    output logic [31:0] SER_CFG_O,
    output logic [31:0] DELIM_CFG_O,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    idio_state_s r, n;
    logic wr, rd, trg_edge, tch_edge, pol, cont, done_ev, busy, queue_ok;
    logic good, shortfall, fault_clr, hist_clr, tick;
    logic [2:0] cond;

    // *****************************************
    // helpers
    // *****************************************
    function automatic logic edge_of(input logic cur, input logic prev, input logic lh);
        edge_of = lh ? (cur & ~prev) : (~cur & prev);
    endfunction

    function automatic logic cond_val(input logic [2:0] sel, input idio_state_s s, input logic c);
        logic rdv, nrv;
        rdv = s.rd_flag;
        nrv = s.nord_flag;
        unique case (idio_cond_e'(sel))
            IDIO_C_PASS: cond_val = c ? (rdv & s.cmp_ok) : rdv;
            IDIO_C_FAIL: cond_val = c ? (nrv | (rdv & ~s.cmp_ok)) : nrv;
            IDIO_C_READ: cond_val = rdv;
            IDIO_C_NOREAD: cond_val = nrv;
            IDIO_C_MATCH: cond_val = s.match_flag;
            IDIO_C_NOMATCH: cond_val = s.nomatch_flag;
            IDIO_C_MISSED: cond_val = s.missed;
            IDIO_C_FAULT: cond_val = s.fault;
        endcase
    endfunction

    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & ~PENABLE & ~PWRITE;
    assign pol = r.ctrl[`IDIO_CTRL_POL];
    assign cont = r.ctrl[`IDIO_CTRL_CONT];
    // third and second stage agree before the edge counts
    assign trg_edge = (r.trg_sync[2] == r.trg_sync[1]) & edge_of(r.trg_sync[2], r.trg_prev, pol);
    assign tch_edge = (r.tch_sync[2] == r.tch_sync[1]) & edge_of(r.tch_sync[2], r.tch_prev, pol);
    assign busy = (r.st != IDIO_S_IDLE);
    assign done_ev = (r.st == IDIO_S_BUSY) & INSP_DONE_I;
    assign good = (CODES_FOUND_I >= r.scan[7:0]);
    assign shortfall = ~good & ~cont;
    assign hist_clr = wr & (PADDR == `IDIO_OFS_CMD) & PWDATA[`IDIO_CMD_HIST];
    assign fault_clr = wr & (PADDR == `IDIO_OFS_CMD) & PWDATA[`IDIO_CMD_FCLR];
    assign queue_ok = ~CHAN_FULL_I;
    assign tick = (r.tick_cnt == 16'(TICK_CYC - 1));

    // *****************************************
    // next state
    // *****************************************
    always_comb begin
        n = r;
        n.cap = 1'b0;
        n.dexp = 1'b0;
        n.iexp = 1'b0;
        n.drop = 1'b0;
        n.trg_sync = {r.trg_sync[1:0], TRIGGER_I};
        n.tch_sync = {r.tch_sync[1:0], TEACH_I};
        if (r.trg_sync[2] == r.trg_sync[1]) begin
            n.trg_prev = r.trg_sync[2];
        end
        if (r.tch_sync[2] == r.tch_sync[1]) begin
            n.tch_prev = r.tch_sync[2];
        end
        if (!r.pol_seen) begin
            n.pol_seen = 1'b1;
            n.ctrl[`IDIO_CTRL_POL] = ~SINK_VARIANT_I;
            n.trg_prev = SINK_VARIANT_I;
            n.tch_prev = SINK_VARIANT_I;
            // preload idle level, else a false edge follows reset on sinking parts
            n.trg_sync = {SINK_VARIANT_I, SINK_VARIANT_I, SINK_VARIANT_I};
            n.tch_sync = {SINK_VARIANT_I, SINK_VARIANT_I, SINK_VARIANT_I};
        end
        n.tick_cnt = tick ? 16'h0000 : r.tick_cnt + 16'h0001;
        if (trg_edge && !busy) begin
            n.st = IDIO_S_BUSY;
            n.cap = 1'b1;
        end
        if (done_ev) begin
            n.rd_flag = good;
            n.nord_flag = shortfall;
            n.cmp_ok = CMP_OK_I & r.ctrl[`IDIO_CTRL_CMP];
            n.match_flag = good & CMP_OK_I;
            n.nomatch_flag = good & ~CMP_OK_I;
            n.res_seen = 1'b1;
            n.dexp = r.ctrl[`IDIO_CTRL_DEXP] & queue_ok;
            n.iexp = r.ctrl[`IDIO_CTRL_IEXP] & r.ctrl[`IDIO_CTRL_ETH] & queue_ok;
            if (r.ctrl[`IDIO_CTRL_HOLD] && !queue_ok) begin
                n.st = IDIO_S_QUEUE;
            end else begin
                n.drop = ~queue_ok & (r.ctrl[`IDIO_CTRL_DEXP] | r.ctrl[`IDIO_CTRL_IEXP]);
                n.st = IDIO_S_IDLE;
            end
        end
        if (r.st == IDIO_S_QUEUE && queue_ok) begin
            n.dexp = r.ctrl[`IDIO_CTRL_DEXP];
            n.iexp = r.ctrl[`IDIO_CTRL_IEXP] & r.ctrl[`IDIO_CTRL_ETH];
            n.st = IDIO_S_IDLE;
        end
        if (hist_clr) begin
            n.missed = 1'b0;
        end
        if (hist_clr || fault_clr) begin
            n.fault = 1'b0;
        end
        if (trg_edge && busy) begin
            n.missed = 1'b1;
        end
        if (FATAL_I) begin
            n.fault = 1'b1;
        end
        for (int i = 0; i < 3; i++) begin
            cond[i] = cond_val(r.outcfg[i*`IDIO_OC_FLD_W +: `IDIO_OC_SEL_W], n,
                r.ctrl[`IDIO_CTRL_CMP]);
            if (r.outcfg[i*`IDIO_OC_FLD_W + `IDIO_OC_PUL]) begin
                if (done_ev) begin
                    n.pul_ms[i*8 +: 8] = cond[i] ?
                        r.outcfg[i*`IDIO_OC_FLD_W + `IDIO_OC_WID_LSB +: 8] : 8'h00;
                end else if (tick && r.pul_ms[i*8 +: 8] != 8'h00) begin
                    n.pul_ms[i*8 +: 8] = r.pul_ms[i*8 +: 8] - 8'h01;
                end
                n.out[i] = (n.pul_ms[i*8 +: 8] != 8'h00);
            end else begin
                n.out[i] = cond[i];
            end
        end
        // apb registers
        if (wr) begin
            unique case (PADDR)
                `IDIO_OFS_CTRL: n.ctrl = PWDATA;
                // bus word holds the low 32 bits; top nibble of output three width kept
                `IDIO_OFS_OUTCFG: n.outcfg = {r.outcfg[35:32], PWDATA};
                `IDIO_OFS_SER: n.ser = PWDATA;
                `IDIO_OFS_DELIM: n.delim = PWDATA;
                `IDIO_OFS_SCAN: n.scan = PWDATA;
                default: n.ctrl = r.ctrl;
            endcase
        end
        if (rd) begin
            unique case (PADDR)
                `IDIO_OFS_CTRL: n.prdata = r.ctrl;
                `IDIO_OFS_OUTCFG: n.prdata = r.outcfg[31:0];
                `IDIO_OFS_SER: n.prdata = r.ser;
                `IDIO_OFS_DELIM: n.prdata = r.delim;
                `IDIO_OFS_STAT: n.prdata = {24'h00_0000, r.fault, r.missed, busy,
                    r.nomatch_flag, r.match_flag, r.nord_flag, r.rd_flag, r.cmp_ok};
                `IDIO_OFS_SCAN: n.prdata = r.scan;
                default: n.prdata = 32'h0000_0000;
            endcase
        end
    end

    // *****************************************
    // registers
    // *****************************************
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            r <= '0;
            r.outcfg <= `IDIO_RST_OUTCFG;
            r.ser <= `IDIO_RST_SER;
            r.delim <= `IDIO_RST_DELIM;
            r.scan <= `IDIO_RST_SCAN;
            r.st <= IDIO_S_IDLE;
        end else begin
            r <= n;
        end
    end

    // *****************************************
    // outputs
    // *****************************************
    assign RESULT_O = r.out;
    assign READY_O = ~busy;
    assign TEACH_O = tch_edge;
    assign CAPTURE_O = r.cap;
    assign DATA_EXP_O = r.dexp;
    assign IMG_EXP_O = r.iexp;
    assign DROP_O = r.drop;
    assign DELIM_CFG_O = r.delim;
    assign SER_CFG_O = r.ser;
    assign PRDATA = r.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = `IDIO_PSLVERR_OK;

    // *****************************************
    // checks
    // *****************************************
    sequence trig_busy_s;
        trg_edge && busy;
    endsequence

    missed_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        trig_busy_s |=> r.missed) else $error("missed trigger not flagged");
    missed_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        r.missed && !hist_clr |=> r.missed) else $error("missed trigger dropped");
    fault_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        FATAL_I |=> r.fault) else $error("fault not set");
    capture_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        trg_edge && !busy |=> CAPTURE_O && !READY_O) else $error("capture not started");
    noread_cont_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        done_ev && cont |=> !r.nord_flag) else $error("no-read in continuous");
    hold_ready_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        r.st == IDIO_S_QUEUE && CHAN_FULL_I |=> !READY_O) else $error("ready early");
    nohold_ready_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        done_ev && !r.ctrl[`IDIO_CTRL_HOLD] |=> READY_O) else $error("ready late");
    match_pair_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        done_ev |=> !(r.match_flag && r.nomatch_flag)) else $error("match and nomatch");
    image_eth_a: assert property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        IMG_EXP_O |-> r.ctrl[`IDIO_CTRL_ETH]) else $error("image export off ethernet");

endmodule
`default_nettype wire

// *** dv/idio_plc_model.sv ***
// controller and inspection core stand-in facing the discrete io block
`timescale 1ns/100ps
`default_nettype none
module idio_plc_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // block outputs watched
    input wire logic ready_i,
    input wire logic capture_i,
    // settings from the bench
    input wire logic pol_i,
    input wire logic [7:0] codes_i,
    input wire logic cmp_i,
    input wire logic [7:0] lat_i,
    // pins and core answers
    output logic trig_o,
    output logic teach_o,
    output logic done_o = 1'b0,
    output logic [7:0] codes_o = 8'h00,
    output logic cmp_o = 1'b0
);
    logic [1:0] pin_r = 2'h0;
    logic [7:0] cnt_r = 8'h00;
    assign trig_o = pin_r[0];
    assign teach_o = pin_r[1];
    // wait for ready unless early is set
    // idle level first, so a polarity change never makes a counted edge
    task automatic pulse(input logic tch, input logic early);
        pin_r[tch] <= !pol_i;
        repeat (6) @(posedge clk_i);
        // a hang here is ended by the bench timeout
        while (!early && ready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        pin_r[tch] <= pol_i;
        repeat (6) @(posedge clk_i);
        pin_r[tch] <= !pol_i;
        repeat (6) @(posedge clk_i);
    endtask
    // one answer per capture
    // result lines scrambled outside the answer cycle
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= cnt_r == 8'h01;
            if (capture_i) begin
                cnt_r <= lat_i;
            end else if (cnt_r != 8'h00) begin
                cnt_r <= cnt_r - 8'h01;
            end
            codes_o <= (cnt_r == 8'h01) ? codes_i : ~codes_o;
            cmp_o <= (cnt_r == 8'h01) ? cmp_i : ~cmp_o;
        end
    end
endmodule
`default_nettype wire

// *** dv/tb_idio_top.sv ***
// self-checking bench for the discrete io block
`include "idio_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin fail_count++; \
    $display("unexpected %s exp %0h seen %0h", n, e, s); end end
module tb_idio_top;
    // ****
    // setup
    // ****
    logic clk = 0, rst_b = 0, sink = 0, full = 0, fatal = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata, ser, dlm;
    logic pol = 1, cmp = 0, trg, tch, done, ccmp, ready, cap, tout, dexp, iexp, drop, prdy, perr;
    logic [7:0] codes = 8'h01, lat = 8'h04, ccodes;
    logic [2:0] res;
    int fail_count = 0, num_checks = 0, cyc = 0, n_hi = 0;
    int evt[5] = '{default: 0}, base[5];
    always #10 clk = ~clk;
    idio_top #(.TICK_CYC(4)) i_idio_top (.SYS_CLK_I(clk), .RST_B_I(rst_b), .SINK_VARIANT_I(sink),
        .TRIGGER_I(trg), .TEACH_I(tch), .RESULT_O(res), .READY_O(ready), .TEACH_O(tout),
        .CAPTURE_O(cap), .INSP_DONE_I(done), .CODES_FOUND_I(ccodes), .CMP_OK_I(ccmp),
        .FATAL_I(fatal), .CHAN_FULL_I(full), .DATA_EXP_O(dexp), .IMG_EXP_O(iexp),
        .DROP_O(drop), .SER_CFG_O(ser), .DELIM_CFG_O(dlm), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(prdy),
        .PSLVERR(perr));
    idio_plc_model i_idio_plc_model (.clk_i(clk), .rst_b_i(rst_b), .ready_i(ready),
        .capture_i(cap), .pol_i(pol), .codes_i(codes), .cmp_i(cmp), .lat_i(lat),
        .trig_o(trg), .teach_o(tch), .done_o(done), .codes_o(ccodes), .cmp_o(ccmp));
    // pulse counts; a hang is cut short here
    always @(posedge clk) begin
        cyc++;
        n_hi += res[0];
        evt[0] += cap;
        evt[1] += dexp;
        evt[2] += iexp;
        evt[3] += drop;
        evt[4] += tout;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        `CHK("pslverr", 1'b0, perr)
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input string s, input logic [11:0] a, input logic [31:0] m, e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(s, e, rd & m)
    endtask
    task automatic waitrdy();
        while (ready !== 1'b1) begin
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic insp(input logic [7:0] c, input logic k);
        codes <= c;
        cmp <= k;
        i_idio_plc_model.pulse(1'b0, 1'b0);
        waitrdy();
    endtask
    // ****
    // tests
    // ****
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rc("ctrl", `IDIO_OFS_CTRL, 32'h1, 32'h1);
        rc("unmapped", 12'h0FC, 32'hFFFF_FFFF, 32'h0);
        wr(`IDIO_OFS_CTRL, 8'h09);
        insp(8'h01, 1'b0);
        `CHK("result", 3'b101, res)
        `CHK("capture", 1, evt[0])
        `CHK("data", 1, evt[1])
        insp(8'h00, 1'b0);
        `CHK("result", 3'b010, res)
        rc("stat", `IDIO_OFS_STAT, 8'h06, 8'h04);
        wr(`IDIO_OFS_CTRL, 8'h0B);
        insp(8'h01, 1'b0);
        `CHK("result", 3'b010, res)
        rc("stat", `IDIO_OFS_STAT, 8'h18, 8'h10);
        insp(8'h01, 1'b1);
        rc("stat", `IDIO_OFS_STAT, 8'h18, 8'h08);
        // all eight conditions on output one after a good compared read
        for (int k = 0; k < 8; k++) begin
            wr(`IDIO_OFS_OUTCFG, 32'h2032_1320 | k);
            insp(8'h01, 1'b1);
            `CHK("cond", k[2:0] inside {0, 2, 4}, res[0])
        end
        wr(`IDIO_OFS_OUTCFG, 32'h2032_1326);
        lat <= 8'd60;
        base = evt;
        i_idio_plc_model.pulse(1'b0, 1'b0);
        i_idio_plc_model.pulse(1'b0, 1'b1);
        waitrdy();
        `CHK("capture", 1, evt[0] - base[0])
        `CHK("missed", 1'b1, res[0])
        rc("stat", `IDIO_OFS_STAT, 8'h40, 8'h40);
        wr(`IDIO_OFS_CMD, 8'h01);
        rc("stat", `IDIO_OFS_STAT, 8'h40, 8'h00);
        lat <= 8'd4;
        wr(`IDIO_OFS_OUTCFG, 32'h2032_1327);
        for (int c = 1; c <= 2; c++) begin
            fatal <= 1'b1;
            @(posedge clk);
            fatal <= 1'b0;
            rc("stat", `IDIO_OFS_STAT, 8'h80, 8'h80);
            `CHK("fault", 1'b1, res[0])
            wr(`IDIO_OFS_CMD, c);
            rc("stat", `IDIO_OFS_STAT, 8'h80, 8'h00);
        end
        // pulsed pass output, 3 ms at four cycles a tick
        wr(`IDIO_OFS_OUTCFG, 32'h2032_1038);
        n_hi = 0;
        insp(8'h01, 1'b1);
        repeat (20) @(posedge clk);
        `CHK("pulse", 1'b1, n_hi >= 9 && n_hi <= 13)
        wr(`IDIO_OFS_OUTCFG, 32'h2032_1320);
        wr(`IDIO_OFS_CTRL, 8'h3F);
        full <= 1'b1;
        base = evt;
        i_idio_plc_model.pulse(1'b0, 1'b0);
        repeat (20) @(posedge clk);
        `CHK("ready", 1'b0, ready)
        full <= 1'b0;
        waitrdy();
        `CHK("exports", 2, evt[1] + evt[2] - base[1] - base[2])
        wr(`IDIO_OFS_CTRL, 8'h3B);
        full <= 1'b1;
        base = evt;
        insp(8'h01, 1'b1);
        `CHK("drop", 1, evt[3] - base[3])
        `CHK("exports", 0, evt[1] + evt[2] - base[1] - base[2])
        full <= 1'b0;
        wr(`IDIO_OFS_CTRL, 8'h1B);
        base = evt;
        insp(8'h01, 1'b1);
        `CHK("image", 0, evt[2] - base[2])
        `CHK("data", 1, evt[1] - base[1])
        pol <= 1'b0;
        wr(`IDIO_OFS_CTRL, 8'h0A);
        base = evt;
        insp(8'h01, 1'b1);
        i_idio_plc_model.pulse(1'b1, 1'b0);
        `CHK("capture", 1, evt[0] - base[0])
        `CHK("teach", 1, evt[4] - base[4])
        wr(`IDIO_OFS_SER, 32'h0001_C2A5);
        wr(`IDIO_OFS_DELIM, 32'h0027_0A3B);
        `CHK("serial", 32'h0001_C2A5, ser)
        `CHK("delim", 32'h0027_0A3B, dlm)
        // continuous scanning, just before the reset test: a read short of the scan count leaves the no-read flag clear
        pol <= 1'b1;
        wr(`IDIO_OFS_CTRL, 8'h49);
        insp(8'h00, 1'b0);
        rc("stat", `IDIO_OFS_STAT, 8'h04, 8'h00);
        rst_b <= 1'b0;
        sink <= 1'b1;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        rc("ctrl", `IDIO_OFS_CTRL, 32'h1, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
